/* verilog/qrs_pkg.sv */
// qrs_pkg: constants for the quiesce/response message handler.
// assumes a 32-bit apb slave and a 16-byte application frame sender.
package qrs_pkg;
  // table shape
  localparam int NUM_ENT  = 4;
  localparam int NUM_PATH = 2;
  // message codes
  localparam logic [7:0] SMS_RESPONSE   = 8'h03;
  localparam logic [7:0] SMS_DATA_READY = 8'h20;
  localparam logic [7:0] CHAN_SMS       = 8'h00;
  // return codes
  localparam logic [7:0] RC_SUCCESS   = 8'h00;
  localparam logic [7:0] RC_NO_IO     = 8'h01;
  localparam logic [7:0] RC_UID_UNKN  = 8'h02;
  localparam logic [7:0] RC_BAD_PATH  = 8'h03;
  localparam logic [7:0] RC_OVERLAP   = 8'h04;
  localparam logic [7:0] RC_FAILED    = 8'hfe;
  localparam logic [7:0] RC_INV_FIELD = 8'hff;
  // frame type code for application frames (value arbitrary)
  localparam logic [1:0] FRAME_TYPE_APP = 2'h1;
  // frame lengths in bytes
  localparam logic [4:0] LEN_RESP = 5'd4;
  localparam logic [4:0] LEN_DR   = 5'd16;
  // register byte offsets
  localparam logic [11:0] OFF_QCTRL    = 12'h000;
  localparam logic [11:0] OFF_QTAG     = 12'h004;
  localparam logic [11:0] OFF_QPATH    = 12'h008;
  localparam logic [11:0] OFF_QUID_LO  = 12'h00c;
  localparam logic [11:0] OFF_QUID_HI  = 12'h010;
  localparam logic [11:0] OFF_QSTAT    = 12'h014;
  localparam logic [11:0] OFF_TUID_LO  = 12'h018;
  localparam logic [11:0] OFF_TUID_HI  = 12'h01c;
  localparam logic [11:0] OFF_TPATH0   = 12'h020;
  localparam logic [11:0] OFF_TPATH1   = 12'h024;
  localparam logic [11:0] OFF_TCMD     = 12'h028;
  localparam logic [11:0] OFF_DR_TAG   = 12'h02c;
  localparam logic [11:0] OFF_DR_OFS   = 12'h030;
  localparam logic [11:0] OFF_DR_CNT   = 12'h034;
  localparam logic [11:0] OFF_DR_XID   = 12'h038;
  localparam logic [11:0] OFF_DR_CMD   = 12'h03c;
  // field positions
  localparam int QCTRL_GO   = 0;
  localparam int QCTRL_RCTE = 1;
  localparam int TCMD_LOAD  = 0;
  localparam int TCMD_PV_LO = 1;
  localparam int TCMD_IDX   = 4;
  localparam int DRCMD_SEND = 0;
  // reset value of the 32-bit registers
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : qrs_pkg

/* verilog/qrs_cfg_entry.sv */
// qrs_cfg_entry: one configutor table entry (unique id plus return paths).
// assumes load, clear and remove strobes are never raised together.
`timescale 1ns/1ns
module qrs_cfg_entry (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [63:0] load_uid,
  input  wire logic [31:0] load_path0,
  input  wire logic [31:0] load_path1,
  input  wire logic [1:0]  load_pv,
  input  wire logic        clr_paths,
  input  wire logic        remove,
  input  wire logic [63:0] cmp_uid,
  output logic             valid,
  output logic             match,
  output logic [31:0]      path0,
  output logic [31:0]      path1,
  output logic [1:0]       pv
);
  logic [63:0] uid_reg;  // stored unique id

  // entry storage; load wins over remove and clear, remove drops the entry, clear keeps the id
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid   <= 1'b0;
      uid_reg <= 64'h0;
      path0   <= 32'h0;
      path1   <= 32'h0;
      pv      <= 2'h0;
    end else if (ce) begin
      if (load) begin
        valid   <= 1'b1;
        uid_reg <= load_uid;
        path0   <= load_path0;
        path1   <= load_path1;
        pv      <= load_pv;
      end else if (remove) begin
        valid <= 1'b0;
        pv    <= 2'h0;
      end else if (clr_paths) begin
        pv <= 2'h0;
      end
    end
  end

  // only live entries can match
  assign match = valid && (uid_reg == cmp_uid);
endmodule : qrs_cfg_entry

/* verilog/qrs_handler.sv */
// qrs_handler: quiesce handling, response building and data-ready sending.
// assumes an apb master, a ulp engine answering abort requests, and a
// frame sender that takes one 16-byte frame per tx_valid/tx_ready.
`timescale 1ns/1ns
module qrs_handler (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              abort_req,
  output logic [31:0]       abort_path,
  input  wire logic         abort_ack,
  output logic              tx_valid,
  input  wire logic         tx_ready,
  output logic [1:0]        tx_frame_type,
  output logic [15:0]       tx_chan_field,
  output logic [31:0]       tx_path,
  output logic [4:0]        tx_len,
  output logic [127:0]      tx_data,
  input  wire logic         data_last_sent,
  output logic              dr_outstanding
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOOKUP, ST_ABORT, ST_WAIT,
                            ST_UPDATE, ST_RESP} qrs_state_t;

  qrs_state_t  st_reg;                    // quiesce sequencer state
  logic        rcte_reg;                  // remove-entry flag of request
  logic [15:0] q_tag_reg;                 // request tag
  logic [31:0] q_path_reg;                // request return path
  logic [63:0] q_uid_reg;                 // request unique id
  logic [7:0]  rc_reg;                    // return code of last quiesce
  logic [1:0]  idx_reg;                   // matching entry
  logic        pi_reg;                    // path being aborted
  logic        hit_seen_reg;              // lookup found an entry
  logic [63:0] t_uid_reg;                 // table load staging
  logic [31:0] t_p0_reg, t_p1_reg;        // table load paths
  logic [15:0] dr_tag_reg, dr_xid_reg;    // data-ready tag and id
  logic [31:0] dr_ofs_reg, dr_cnt_reg;    // data-ready offset and count
  logic        dr_pend_reg;               // data-ready waiting to go
  logic        tx_is_resp_reg;            // frame held is a response
  logic        wr_en;                     // apb access phase write strobe
  logic        go_w, tload_w;             // command strobes
  logic        dr_take, resp_take;        // frame loads
  logic        tx_fire;                   // frame accepted by sender
  logic [qrs_pkg::NUM_ENT-1:0] ent_valid, ent_match;  // per-slot live and hit flags
  logic [31:0] ep0 [qrs_pkg::NUM_ENT], ep1 [qrs_pkg::NUM_ENT];  // stored paths per slot
  logic [1:0]  epv [qrs_pkg::NUM_ENT];
  logic        any_hit;                   // some entry matches
  logic [1:0]  hit_idx;                   // lowest matching entry
  logic        lookup_bad;                // return path field unusable

  // all checks below run on the bus clock and pause in reset
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb strobes; ce low stretches the access phase
  assign pready  = ce;
  assign wr_en   = psel && penable && pwrite && ce;
  assign go_w    = wr_en && (paddr == qrs_pkg::OFF_QCTRL) && pwdata[qrs_pkg::QCTRL_GO];
  assign tload_w = wr_en && (paddr == qrs_pkg::OFF_TCMD) && pwdata[qrs_pkg::TCMD_LOAD];
  assign tx_fire = tx_valid && tx_ready && ce;

  // unmapped offsets answer with an error and zero data
  always_comb begin
    prdata  = qrs_pkg::RST_WORD;
    pslverr = 1'b0;
    case (paddr)
      qrs_pkg::OFF_QCTRL:   prdata = {29'h0, dr_outstanding, dr_pend_reg, st_reg != ST_IDLE};
      qrs_pkg::OFF_QTAG:    prdata = {16'h0, q_tag_reg};
      qrs_pkg::OFF_QPATH:   prdata = q_path_reg;
      qrs_pkg::OFF_QUID_LO: prdata = q_uid_reg[31:0];
      qrs_pkg::OFF_QUID_HI: prdata = q_uid_reg[63:32];
      qrs_pkg::OFF_QSTAT:   prdata = {20'h0, ent_valid, rc_reg};
      qrs_pkg::OFF_TUID_LO: prdata = t_uid_reg[31:0];
      qrs_pkg::OFF_TUID_HI: prdata = t_uid_reg[63:32];
      qrs_pkg::OFF_TPATH0:  prdata = t_p0_reg;
      qrs_pkg::OFF_TPATH1:  prdata = t_p1_reg;
      qrs_pkg::OFF_TCMD:    prdata = qrs_pkg::RST_WORD;
      qrs_pkg::OFF_DR_TAG:  prdata = {16'h0, dr_tag_reg};
      qrs_pkg::OFF_DR_OFS:  prdata = dr_ofs_reg;
      qrs_pkg::OFF_DR_CNT:  prdata = dr_cnt_reg;
      qrs_pkg::OFF_DR_XID:  prdata = {16'h0, dr_xid_reg};
      qrs_pkg::OFF_DR_CMD:  prdata = qrs_pkg::RST_WORD;
      default: pslverr = psel && penable;
    endcase
  end

  // request registers; frozen while a quiesce is running so the echo holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_tag_reg  <= 16'h0;
      q_path_reg <= qrs_pkg::RST_WORD;
      q_uid_reg  <= 64'h0;
      rcte_reg   <= 1'b0;
    end else if (wr_en && st_reg == ST_IDLE) begin
      case (paddr)
        qrs_pkg::OFF_QTAG:    q_tag_reg <= pwdata[15:0];
        qrs_pkg::OFF_QPATH:   q_path_reg <= pwdata;
        qrs_pkg::OFF_QUID_LO: q_uid_reg[31:0] <= pwdata;
        qrs_pkg::OFF_QUID_HI: q_uid_reg[63:32] <= pwdata;
        qrs_pkg::OFF_QCTRL:   rcte_reg <= pwdata[qrs_pkg::QCTRL_RCTE];
        default: ;
      endcase
    end
  end

  // table staging and data-ready fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_uid_reg  <= 64'h0;
      t_p0_reg   <= qrs_pkg::RST_WORD;
      t_p1_reg   <= qrs_pkg::RST_WORD;
      dr_tag_reg <= 16'h0;
      dr_ofs_reg <= qrs_pkg::RST_WORD;
      dr_cnt_reg <= qrs_pkg::RST_WORD;
      dr_xid_reg <= 16'h0;
    end else if (wr_en) begin
      case (paddr)
        qrs_pkg::OFF_TUID_LO: t_uid_reg[31:0] <= pwdata;
        qrs_pkg::OFF_TUID_HI: t_uid_reg[63:32] <= pwdata;
        qrs_pkg::OFF_TPATH0:  t_p0_reg <= pwdata;
        qrs_pkg::OFF_TPATH1:  t_p1_reg <= pwdata;
        qrs_pkg::OFF_DR_TAG:  dr_tag_reg <= pwdata[15:0];
        qrs_pkg::OFF_DR_OFS:  dr_ofs_reg <= pwdata;
        qrs_pkg::OFF_DR_CNT:  dr_cnt_reg <= pwdata;
        qrs_pkg::OFF_DR_XID:  dr_xid_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // configutor table, one entry module per slot
  genvar gi;
  generate
    for (gi = 0; gi < qrs_pkg::NUM_ENT; gi++) begin : g_ent
      wire logic sel_ent = (st_reg == ST_UPDATE) && (idx_reg == 2'(gi));  // quiesce target
      qrs_cfg_entry u_ent (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .load       (tload_w && st_reg == ST_IDLE &&
                     pwdata[qrs_pkg::TCMD_IDX +: 2] == 2'(gi)),
        .load_uid   (t_uid_reg),
        .load_path0 (t_p0_reg),
        .load_path1 (t_p1_reg),
        .load_pv    (pwdata[qrs_pkg::TCMD_PV_LO +: 2]),
        .clr_paths  (sel_ent && !rcte_reg),
        .remove     (sel_ent && rcte_reg),
        .cmp_uid    (q_uid_reg),
        .valid      (ent_valid[gi]),
        .match      (ent_match[gi]),
        .path0      (ep0[gi]),
        .path1      (ep1[gi]),
        .pv         (epv[gi])
      );
    end
  endgenerate

  // lowest matching slot wins; loads keep ids distinct in practice
  always_comb begin
    any_hit = 1'b0;
    hit_idx = 2'h0;
    for (int i = qrs_pkg::NUM_ENT - 1; i >= 0; i--) begin
      if (ent_match[i]) begin
        any_hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
  end

  // a zero return path cannot address the response's sender
  assign lookup_bad = (q_path_reg == qrs_pkg::RST_WORD);

  // quiesce sequencer: lookup, abort per path, update, answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= ST_IDLE;
      rc_reg       <= qrs_pkg::RC_SUCCESS;
      idx_reg      <= 2'h0;
      pi_reg       <= 1'b0;
      hit_seen_reg <= 1'b0;
      abort_req    <= 1'b0;
      abort_path   <= qrs_pkg::RST_WORD;
    end else if (ce) begin
      case (st_reg)
        ST_IDLE: begin
          hit_seen_reg <= 1'b0;
          st_reg       <= go_w ? ST_LOOKUP : ST_IDLE;
        end
        // lookup before abort; slot contents stay put until ST_UPDATE
        ST_LOOKUP: begin
          idx_reg <= hit_idx;
          pi_reg  <= 1'b0;
          if (lookup_bad) begin
            rc_reg <= qrs_pkg::RC_INV_FIELD;
            st_reg <= ST_RESP;
          end else if (!any_hit) begin
            rc_reg <= qrs_pkg::RC_UID_UNKN;
            st_reg <= ST_RESP;
          end else begin
            hit_seen_reg <= 1'b1;
            st_reg       <= ST_ABORT;
          end
        end
        ST_ABORT: begin
          if (epv[idx_reg][pi_reg]) begin
            abort_req  <= 1'b1;
            abort_path <= pi_reg ? ep1[idx_reg] : ep0[idx_reg];
            st_reg     <= ST_WAIT;
          end else begin
            pi_reg <= 1'b1;
            st_reg <= pi_reg ? ST_UPDATE : ST_ABORT;
          end
        end
        ST_WAIT: begin
          if (abort_ack) begin
            abort_req <= 1'b0;
            pi_reg    <= 1'b1;
            st_reg    <= pi_reg ? ST_UPDATE : ST_ABORT;
          end
        end
        ST_UPDATE: begin
          rc_reg <= qrs_pkg::RC_SUCCESS;
          st_reg <= ST_RESP;
        end
        ST_RESP: begin
          st_reg <= resp_take ? ST_IDLE : ST_RESP;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // response has priority over a waiting data-ready
  assign resp_take = (st_reg == ST_RESP) && (!tx_valid || tx_fire);
  assign dr_take   = dr_pend_reg && !resp_take && (!tx_valid || tx_fire);

  // frame holding register toward the sender
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid       <= 1'b0;
      tx_is_resp_reg <= 1'b0;
      tx_frame_type  <= qrs_pkg::FRAME_TYPE_APP;
      tx_chan_field  <= 16'h0;
      tx_path        <= qrs_pkg::RST_WORD;
      tx_len         <= 5'h0;
      tx_data        <= 128'h0;
    end else if (ce) begin
      tx_frame_type <= qrs_pkg::FRAME_TYPE_APP;
      tx_chan_field <= {qrs_pkg::CHAN_SMS, 8'h00};
      if (resp_take) begin
        tx_valid       <= 1'b1;
        tx_is_resp_reg <= 1'b1;
        tx_path        <= q_path_reg;
        tx_len  <= qrs_pkg::LEN_RESP;
        tx_data <= {qrs_pkg::SMS_RESPONSE, rc_reg, q_tag_reg, 96'h0};
      end else if (dr_take) begin
        tx_valid       <= 1'b1;
        tx_is_resp_reg <= 1'b0;
        tx_path        <= q_path_reg;
        tx_len         <= qrs_pkg::LEN_DR;
        tx_data        <= {qrs_pkg::SMS_DATA_READY, 8'h00, dr_tag_reg, dr_ofs_reg,
                           dr_cnt_reg, 16'h0, dr_xid_reg};
      end else if (tx_fire) begin
        tx_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dr_pend_reg    <= 1'b0;
      dr_outstanding <= 1'b0;
    end else if (ce) begin
      dr_pend_reg <= (wr_en && paddr == qrs_pkg::OFF_DR_CMD && pwdata[qrs_pkg::DRCMD_SEND]) ||
                     (dr_pend_reg && !dr_take);
      // set on send wins over last frame
      dr_outstanding <= (tx_fire && !tx_is_resp_reg) || (dr_outstanding && !data_last_sent);
    end
  end

  property p_resp_code;
    tx_valid && tx_is_resp_reg |-> tx_data[127:120] == 8'h03 && tx_len == 5'd4;
  endproperty
  a_resp_code: assert property (p_resp_code) else $error("bad response code");
  property p_tag_path;
    tx_valid && tx_is_resp_reg |-> tx_data[111:96] == q_tag_reg && tx_path == q_path_reg;
  endproperty
  a_tag_path: assert property (p_tag_path) else $error("tag or path not echoed");
  property p_chan;
    tx_valid |-> tx_chan_field[15:8] == 8'h00 && tx_frame_type == qrs_pkg::FRAME_TYPE_APP;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel or frame type");
  property p_nomatch;
    ce && st_reg == ST_LOOKUP && !any_hit && !lookup_bad |=>
      st_reg == ST_RESP && rc_reg == 8'h02 && $stable(ent_valid);
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("unknown id mishandled");
  property p_abort_after_hit;
    abort_req |-> hit_seen_reg && st_reg == ST_WAIT;
  endproperty
  a_abort_after_hit: assert property (p_abort_after_hit) else $error("abort w/o lookup");
  property p_success_order;
    $rose(tx_valid) && tx_is_resp_reg && tx_data[119:112] == 8'h00 |->
      $past(st_reg, 2) == ST_UPDATE || $past(st_reg) == ST_RESP;
  endproperty
  a_success_order: assert property (p_success_order) else $error("answer before update");
  property p_remove;
    ce && st_reg == ST_UPDATE && rcte_reg |=> !ent_valid[idx_reg];
  endproperty
  a_remove: assert property (p_remove) else $error("entry not removed");
  property p_clear;
    ce && st_reg == ST_UPDATE && !rcte_reg |=> ent_valid[idx_reg] && epv[idx_reg] == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("paths not cleared");
  property p_dr_out;
    tx_fire && !tx_is_resp_reg |=> dr_outstanding;
  endproperty
  a_dr_out: assert property (p_dr_out) else $error("data-ready not outstanding");
  property p_dr_code;
    tx_valid && !tx_is_resp_reg |-> tx_data[127:120] == 8'h20 && tx_len == 5'd16;
  endproperty
  a_dr_code: assert property (p_dr_code) else $error("bad data-ready layout");

  c_remove:  cover property (@(posedge pclk) st_reg == ST_UPDATE && rcte_reg);
  c_clear:   cover property (@(posedge pclk) st_reg == ST_UPDATE && !rcte_reg);
  c_nomatch: cover property (@(posedge pclk) tx_fire && rc_reg == 8'h02);
  c_dr:      cover property (@(posedge pclk) tx_fire && !tx_is_resp_reg);
endmodule : qrs_handler

/* test/qrs_far_model.sv */
// qrs_far_model: abort engine and frame sink facing the handler.
// assumes one clock shared with the handler; slow adds random stalls.
`timescale 1ns/1ns
module qrs_far_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic allow_last,
  input  wire logic abort_req,
  input  wire logic dr_outstanding,
  output logic      abort_ack,
  output logic      tx_ready,
  output logic      data_last_sent
);
  logic [15:0] lfsr_reg; // stall pattern source
  // stall pattern moves every cycle so waits differ
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lfsr_reg <= 16'hace1;
    else lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end
  // one ack pulse per abort request, late when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) abort_ack <= 1'b0;
    else abort_ack <= abort_req & ~abort_ack & (~slow | lfsr_reg[1]);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) data_last_sent <= 1'b0;
    else data_last_sent <= dr_outstanding & allow_last & ~data_last_sent;
  end
  // sink may refuse frames for a while
  assign tx_ready = ~slow | lfsr_reg[0];
endmodule : qrs_far_model

/* test/qrs_handler_tb.sv */
// qrs_handler_tb: apb driven quiesce, response and data-ready checks.
// assumes the far model answers aborts and frames; ce dropped once.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module qrs_handler_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, allow_last = 0;
  logic ce = 1;                // clock enable, dropped once to freeze the block
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, abort_path, tx_path, r, seed = 32'hbf25146e;
  logic pready, pslverr, abort_req, abort_ack, tx_valid, tx_ready, dls, dro, e;
  logic [1:0] tx_frame_type;
  logic [15:0] tx_chan_field, tag;
  logic [4:0] tx_len;
  logic [127:0] tx_data;
  logic [164:0] fq[$], f;     // accepted frames: len, path, bytes
  logic [31:0] ab_q[$], eq[$]; // aborted paths seen and expected
  logic [63:0] uid;
  logic [31:0] p0, p1, q, ofs, cnt;
  logic [3:0] vm = 0;          // expected entry valid mask
  int n_fail = 0, total_checks = 0;
  qrs_handler qrs_handler_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .abort_req(abort_req), .abort_path(abort_path),
    .abort_ack(abort_ack), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_frame_type(tx_frame_type), .tx_chan_field(tx_chan_field), .tx_path(tx_path),
    .tx_len(tx_len), .tx_data(tx_data), .data_last_sent(dls), .dr_outstanding(dro));
  qrs_far_model qrs_far_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .allow_last(allow_last), .abort_req(abort_req), .dr_outstanding(dro),
    .abort_ack(abort_ack), .tx_ready(tx_ready), .data_last_sent(dls));
  initial forever #25 pclk = ~pclk;
  // capture frames and abort handshakes at accepting edges
  always @(posedge pclk) begin
    if (abort_req === 1'b1 && abort_ack === 1'b1) ab_q.push_back(abort_path);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      fq.push_back({tx_len, tx_path, tx_data});
      `CHK(tx_frame_type, qrs_pkg::FRAME_TYPE_APP)
      `CHK(tx_chan_field[15:8], qrs_pkg::CHAN_SMS)
    end
  end
  task summarize;
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // one apb transfer, held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin n_fail++; summarize(); end
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  task wait_frame;
    int k;
    for (k = 0; k < 400 && fq.size() == 0; k++) @(posedge pclk);
    if (k == 400) begin n_fail++; summarize(); end
    f = fq.pop_front();
  endtask : wait_frame
  function automatic logic [164:0] resp(logic [31:0] p, logic [7:0] rc, logic [15:0] t);
    return {qrs_pkg::LEN_RESP, p, qrs_pkg::SMS_RESPONSE, rc, t, 96'h0};
  endfunction : resp
  task quiesce(input logic [63:0] u, input logic [31:0] p, input logic rcte);
    apb(1, qrs_pkg::OFF_QUID_LO, u[31:0]); apb(1, qrs_pkg::OFF_QUID_HI, u[63:32]);
    apb(1, qrs_pkg::OFF_QTAG, {16'h0, tag}); apb(1, qrs_pkg::OFF_QPATH, p);
    ab_q.delete(); apb(1, qrs_pkg::OFF_QCTRL, {30'h0, rcte, 1'b1}); wait_frame();
  endtask : quiesce
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, qrs_pkg::OFF_QSTAT, 0);
    `CHK(r, qrs_pkg::RST_WORD)
    apb(0, 12'h040, 0);
    `CHK({e, r}, {1'b1, 32'h0})
    for (int i = 0; i < 4; i++) begin
      // fresh tag, rcte only on odd entries
      uid = {$random(seed), $random(seed)}; tag = 16'($random(seed));
      p0 = $random(seed) | 1; p1 = $random(seed) | 2; q = $random(seed) | 4;
      slow <= i[1]; vm[i] = ~i[0]; eq.delete();
      if (i[0]) eq.push_back(p0);
      if (i[1]) eq.push_back(p1);
      apb(1, qrs_pkg::OFF_TUID_LO, uid[31:0]); apb(1, qrs_pkg::OFF_TUID_HI, uid[63:32]);
      apb(1, qrs_pkg::OFF_TPATH0, p0); apb(1, qrs_pkg::OFF_TPATH1, p1);
      apb(1, qrs_pkg::OFF_TCMD, (i << 4) | (i << 1) | 1);
      quiesce(uid, q, i[0]);
      `CHK(f, resp(q, qrs_pkg::RC_SUCCESS, tag))
      `CHK(ab_q.size(), eq.size())
      foreach (eq[j]) `CHK(ab_q[j], eq[j])
      apb(0, qrs_pkg::OFF_QSTAT, 0);
      `CHK(r[11:0], {vm, qrs_pkg::RC_SUCCESS})
    end
    tag = 16'($random(seed));
    quiesce(uid, q, 1'b0);
    `CHK(f, resp(q, qrs_pkg::RC_UID_UNKN, tag))
    apb(0, qrs_pkg::OFF_QSTAT, 0);
    `CHK(r[11:8], vm)
    quiesce(uid, 32'h0, 1'b0);
    `CHK(f, resp(32'h0, qrs_pkg::RC_INV_FIELD, tag))
    tag = 16'($random(seed)); ofs = $random(seed); cnt = $random(seed); q = $random(seed) | 1;
    apb(1, qrs_pkg::OFF_QPATH, q); apb(1, qrs_pkg::OFF_DR_TAG, {16'h0, tag});
    apb(1, qrs_pkg::OFF_DR_OFS, ofs); apb(1, qrs_pkg::OFF_DR_CNT, cnt);
    apb(1, qrs_pkg::OFF_DR_XID, {16'h0, ~tag}); apb(1, qrs_pkg::OFF_DR_CMD, 1);
    wait_frame();
    `CHK(f, {qrs_pkg::LEN_DR, q, 16'h2000, tag, ofs, cnt, 16'h0, ~tag})
    @(posedge pclk);
    `CHK(dro, 1'b1)
    ce <= 0;
    allow_last <= 1;
    repeat (4) @(posedge pclk);
    `CHK(dro, 1'b1)
    ce <= 1;
    repeat (4) @(posedge pclk);
    `CHK(dro, 1'b0)
    summarize();
  end
endmodule : qrs_handler_tb
